/* File: hw/tmc_pkg.sv */
// Package: register map, field layout and constants of the 8-bit compare timer
package tmc_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [2:0] TMC_OFF_CONTROL = 3'h0;
    localparam logic [2:0] TMC_OFF_COUNT   = 3'h1;
    localparam logic [2:0] TMC_OFF_COMPARE = 3'h2;
    localparam logic [2:0] TMC_OFF_MASK    = 3'h3;
    localparam logic [2:0] TMC_OFF_FLAGS   = 3'h4;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int TMC_CTL_WAVE0   = 6;
    localparam int TMC_CTL_WAVE1   = 3;
    localparam int TMC_CTL_COM_LO  = 4;
    localparam int TMC_CTL_CS_LO   = 0;
    localparam int TMC_BIT_OVF     = 1;
    localparam int TMC_BIT_CMP     = 0;

    // ----------------------------------------
    // Reset values and fixed levels
    // ----------------------------------------
    localparam logic [7:0] TMC_RESET_BYTE = 8'h00;
    localparam logic [7:0] TMC_MAX        = 8'hFF;
    localparam logic [7:0] TMC_BOTTOM     = 8'h00;

    // ----------------------------------------
    // Prescaler taps (cycles per tick, minus one)
    // ----------------------------------------
    localparam logic [9:0] TMC_DIV8_MASK    = 10'h007;
    localparam logic [9:0] TMC_DIV64_MASK   = 10'h03F;
    localparam logic [9:0] TMC_DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] TMC_DIV1024_MASK = 10'h3FF;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        TMC_WAVE_NORMAL,
        TMC_WAVE_PHASE,
        TMC_WAVE_CTC,
        TMC_WAVE_FAST
    } tmc_wave_e;

    typedef enum logic [2:0] {
        TMC_CS_STOP,
        TMC_CS_DIV1,
        TMC_CS_DIV8,
        TMC_CS_DIV64,
        TMC_CS_DIV256,
        TMC_CS_DIV1024,
        TMC_CS_EXT_FALL,
        TMC_CS_EXT_RISE
    } tmc_cs_e;

    typedef enum logic [1:0] {
        TMC_COM_OFF,
        TMC_COM_TOGGLE,
        TMC_COM_CLEAR,
        TMC_COM_SET
    } tmc_com_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmc_bus_req_s;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] count;
        logic [7:0] compare;
        logic [1:0] mask;
        logic [1:0] flags;
        logic       count_up;
        logic       block_match;
        logic       wave_out;
        logic [9:0] prescale;
        logic [2:0] ext_sync;
        logic [7:0] rdata;
        logic       pin_out;
        logic       pin_oe;
        logic       irq_overflow;
        logic       irq_compare;
        logic       irq;
    } tmc_state_s;

endpackage : tmc_pkg

/* File: hw/tmc_timer8.sv */
// Module: 8-bit timer/counter with one compare channel and waveform output
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// What this block does
// [R1] Nonzero compare mode drives waveform on pin; driver enabled by direction bit.
// [R2] Normal/clear-on-match: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R3] Fast PWM: 01 reserved; 10 clear on match set at TOP; 11 inverse.
// [R4] Phase correct: 10 clears on up match, sets on down match; 11 inverse.
// [R5] PWM with compare equal TOP and upper mode bit: ignore match, act at TOP.
// [R6] Clock source 000 stop, 001 undivided, 010..101 divide 8/64/256/1024.
// [R7] Source 110 counts falling external edges, 111 counts rising edges.
// [R8] External edges count even while the count pin is an output.
// [R9] Software reads and writes the 8-bit counter directly.
// [R10] A counter write suppresses the compare match on the next timer clock.
// [R11] Compare register checked on every timer clock; match feeds interrupt and waveform.
// [R12] Overflow request when mask bit 1, global enable and overflow flag set.
// [R13] Compare request when mask bit 0, global enable and compare flag set.
// [R14] Overflow flag on wrap; in phase correct on turning at bottom.
// [R15] Flags clear on vector execution or by writing one.
// [R16] Compare flag, bit 0, set on a timer clock where counter equals compare value and the match is not blocked.
// [R17] Mode 0 normal, 1 phase correct, 2 clear-on-match, 3 fast PWM.
// [R18] Writing zero leaves flags; vector clear comes from acknowledge pulses.
// [R19] Everything resets to zero: timer stopped, output disconnected.
// ----------------------------------------
module tmc_timer8
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire tmc_pkg::tmc_bus_req_s bus_req,
    output logic [7:0]             bus_rdata,
    // Interrupt side
    input  wire logic              global_irq_enable,
    input  wire logic              overflow_ack,
    input  wire logic              compare_ack,
    output logic                   irq_overflow,
    output logic                   irq_compare,
    output logic                   irq,
    // Port pins
    input  wire logic              external_count_pin,
    input  wire logic              port_data_out,
    input  wire logic              port_dir_out,
    output logic                   waveform_output_pin,
    output logic                   waveform_output_pin_oe
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    tmc_pkg::tmc_state_s state_reg;
    tmc_pkg::tmc_state_s state_next;

    tmc_pkg::tmc_wave_e  wave_mode;
    tmc_pkg::tmc_cs_e    clock_source_select;
    tmc_pkg::tmc_com_e   compare_output_mode;

    assign wave_mode = tmc_pkg::tmc_wave_e'({state_reg.control[tmc_pkg::TMC_CTL_WAVE1],
                                             state_reg.control[tmc_pkg::TMC_CTL_WAVE0]});
    assign clock_source_select =
        tmc_pkg::tmc_cs_e'(state_reg.control[tmc_pkg::TMC_CTL_CS_LO +: 3]);
    assign compare_output_mode =
        tmc_pkg::tmc_com_e'(state_reg.control[tmc_pkg::TMC_CTL_COM_LO +: 2]);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic       tick;
        logic       ext_rise;
        logic       ext_fall;
        logic       match;
        logic       at_top;
        logic       pwm;
        logic       ovf_event;
        logic       cmp_event;
        logic       com_hi;
        logic [1:0] clr;
        logic       wave;

        tick       = 1'b0;
        clr        = 2'h0;
        match      = 1'b0;
        at_top     = 1'b0;
        ovf_event  = 1'b0;
        cmp_event  = 1'b0;
        state_next = state_reg;
        wave       = state_reg.wave_out;
        com_hi     = compare_output_mode[1];
        pwm        = (wave_mode == tmc_pkg::TMC_WAVE_PHASE) ||
                     (wave_mode == tmc_pkg::TMC_WAVE_FAST);

        // Pin sampled every cycle regardless of its direction
        state_next.ext_sync = {state_reg.ext_sync[1:0], external_count_pin}; // see [R8]
        ext_rise = state_reg.ext_sync[1] & ~state_reg.ext_sync[2];
        ext_fall = ~state_reg.ext_sync[1] & state_reg.ext_sync[2];

        // Free-running prescaler
        state_next.prescale = state_reg.prescale + 10'h001;

        // ----------------------------------------
        // Count clock selection
        // ----------------------------------------
        case (clock_source_select)
            tmc_pkg::TMC_CS_STOP:     tick = 1'b0; // see [R6]
            tmc_pkg::TMC_CS_DIV1:     tick = 1'b1; // see [R6]
            tmc_pkg::TMC_CS_DIV8:
                tick = (state_reg.prescale & tmc_pkg::TMC_DIV8_MASK) == 10'h000; // see [R6]
            tmc_pkg::TMC_CS_DIV64:
                tick = (state_reg.prescale & tmc_pkg::TMC_DIV64_MASK) == 10'h000;
            tmc_pkg::TMC_CS_DIV256:
                tick = (state_reg.prescale & tmc_pkg::TMC_DIV256_MASK) == 10'h000;
            tmc_pkg::TMC_CS_DIV1024:
                tick = (state_reg.prescale & tmc_pkg::TMC_DIV1024_MASK) == 10'h000;
            tmc_pkg::TMC_CS_EXT_FALL: tick = ext_fall; // see [R7]
            tmc_pkg::TMC_CS_EXT_RISE: tick = ext_rise; // see [R7]
            default:                  tick = 1'b0;
        endcase

        // ----------------------------------------
        // Counter and compare
        // ----------------------------------------
        if (tick)
        begin
            match = (state_reg.count == state_reg.compare) && !state_reg.block_match; // see [R10]
            state_next.block_match = 1'b0;
            at_top = (state_reg.count == tmc_pkg::TMC_MAX);
            cmp_event = match; // see [R11] [R16]
            case (wave_mode)
                tmc_pkg::TMC_WAVE_PHASE:
                begin
                    if (state_reg.count_up)
                    begin
                        if (at_top)
                        begin
                            state_next.count_up = 1'b0;
                            state_next.count    = state_reg.count - 8'h01;
                        end
                        else
                        begin
                            state_next.count = state_reg.count + 8'h01;
                        end
                    end
                    else if (state_reg.count == tmc_pkg::TMC_BOTTOM)
                    begin
                        state_next.count_up = 1'b1;
                        state_next.count    = state_reg.count + 8'h01;
                        ovf_event           = 1'b1; // see [R14]
                    end
                    else
                    begin
                        state_next.count = state_reg.count - 8'h01;
                    end
                end
                tmc_pkg::TMC_WAVE_CTC:
                begin
                    state_next.count = match ? tmc_pkg::TMC_BOTTOM : state_reg.count + 8'h01; // see [R17]
                    ovf_event        = at_top; // see [R14]
                end
                default:
                begin
                    state_next.count = state_reg.count + 8'h01; // see [R17]
                    ovf_event        = at_top; // see [R14]
                end
            endcase

            // ----------------------------------------
            // Waveform generation
            // ----------------------------------------
            if (pwm && com_hi && state_reg.compare == tmc_pkg::TMC_MAX)
            begin
                match = 1'b0; // see [R5]
            end
            case (wave_mode)
                tmc_pkg::TMC_WAVE_FAST:
                begin
                    if (compare_output_mode == tmc_pkg::TMC_COM_CLEAR)
                    begin
                        wave = match ? 1'b0 : (at_top ? 1'b1 : wave); // see [R3]
                    end
                    else if (compare_output_mode == tmc_pkg::TMC_COM_SET)
                    begin
                        wave = match ? 1'b1 : (at_top ? 1'b0 : wave); // see [R3]
                    end
                end
                tmc_pkg::TMC_WAVE_PHASE:
                begin
                    if (com_hi)
                    begin
                        clr = {compare_output_mode == tmc_pkg::TMC_COM_CLEAR, state_reg.count_up};
                        if (match)
                        begin
                            wave = (clr[1] ^ clr[0]) ? 1'b1 : 1'b0; // see [R4]
                        end
                        else if (at_top && state_reg.compare == tmc_pkg::TMC_MAX)
                        begin
                            wave = clr[1]; // see [R5]
                        end
                    end
                end
                default:
                begin
                    if (match)
                    begin
                        case (compare_output_mode)
                            tmc_pkg::TMC_COM_TOGGLE: wave = ~state_reg.wave_out; // see [R2]
                            tmc_pkg::TMC_COM_CLEAR:  wave = 1'b0; // see [R2]
                            tmc_pkg::TMC_COM_SET:    wave = 1'b1; // see [R2]
                            default:                 wave = state_reg.wave_out;
                        endcase
                    end
                end
            endcase
            state_next.wave_out = wave;
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        state_next.rdata = 8'h00;
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                tmc_pkg::TMC_OFF_CONTROL: state_next.control = {1'b0, bus_req.wdata[6:0]};
                tmc_pkg::TMC_OFF_COUNT:
                begin
                    state_next.count       = bus_req.wdata; // see [R9]
                    state_next.block_match = 1'b1; // see [R10]
                end
                tmc_pkg::TMC_OFF_COMPARE: state_next.compare = bus_req.wdata;
                tmc_pkg::TMC_OFF_MASK:    state_next.mask    = bus_req.wdata[1:0];
                tmc_pkg::TMC_OFF_FLAGS:
                    state_next.flags = state_reg.flags & ~bus_req.wdata[1:0]; // see [R15] [R18]
                default:                  state_next.rdata   = 8'h00;
            endcase
        end

        // ----------------------------------------
        // Flags: hardware clear by acknowledge, set wins
        // ----------------------------------------
        if (overflow_ack)
        begin
            state_next.flags[tmc_pkg::TMC_BIT_OVF] = 1'b0; // see [R15] [R18]
        end
        if (compare_ack)
        begin
            state_next.flags[tmc_pkg::TMC_BIT_CMP] = 1'b0; // see [R15] [R18]
        end
        if (ovf_event)
        begin
            state_next.flags[tmc_pkg::TMC_BIT_OVF] = 1'b1; // see [R14]
        end
        if (cmp_event)
        begin
            state_next.flags[tmc_pkg::TMC_BIT_CMP] = 1'b1; // see [R16]
        end

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                tmc_pkg::TMC_OFF_CONTROL: state_next.rdata = state_reg.control;
                tmc_pkg::TMC_OFF_COUNT:   state_next.rdata = state_reg.count; // see [R9]
                tmc_pkg::TMC_OFF_COMPARE: state_next.rdata = state_reg.compare;
                tmc_pkg::TMC_OFF_MASK:    state_next.rdata = {6'h00, state_reg.mask};
                tmc_pkg::TMC_OFF_FLAGS:   state_next.rdata = {6'h00, state_reg.flags};
                default:                  state_next.rdata = 8'h00;
            endcase
        end

        // ----------------------------------------
        // Interrupt requests and pin
        // ----------------------------------------
        state_next.irq_overflow = global_irq_enable &&
            state_next.mask[tmc_pkg::TMC_BIT_OVF] && state_next.flags[tmc_pkg::TMC_BIT_OVF]; // see [R12]
        state_next.irq_compare = global_irq_enable &&
            state_next.mask[tmc_pkg::TMC_BIT_CMP] && state_next.flags[tmc_pkg::TMC_BIT_CMP]; // see [R13]
        state_next.irq = state_next.irq_overflow || state_next.irq_compare;

        if (state_next.control[tmc_pkg::TMC_CTL_COM_LO +: 2] != 2'h0)
        begin
            state_next.pin_out = state_next.wave_out; // see [R1]
        end
        else
        begin
            state_next.pin_out = port_data_out;
        end
        state_next.pin_oe = port_dir_out; // see [R1]
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0; // see [R19]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata              = state_reg.rdata;
    assign irq_overflow           = state_reg.irq_overflow;
    assign irq_compare            = state_reg.irq_compare;
    assign irq                    = state_reg.irq;
    assign waveform_output_pin    = state_reg.pin_out;
    assign waveform_output_pin_oe = state_reg.pin_oe;

endmodule : tmc_timer8
`default_nettype wire

/* File: verification/test_tmc_timer8.sv */
// Testbench: register-level tests of the 8-bit compare timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module test_tmc_timer8;
    localparam logic [2:0] CTL = tmc_pkg::TMC_OFF_CONTROL;
    localparam logic [2:0] CNT = tmc_pkg::TMC_OFF_COUNT;
    localparam logic [2:0] CMP = tmc_pkg::TMC_OFF_COMPARE;
    localparam logic [2:0] MSK = tmc_pkg::TMC_OFF_MASK;
    localparam logic [2:0] FLG = tmc_pkg::TMC_OFF_FLAGS;
    logic clk, reset_n, gie, ovf_ack, cmp_ack, ext_pin, pdo, pdir;
    logic irq_ovf, irq_cmp, irq, pin, pin_oe;
    logic [7:0] rdata, c;
    tmc_pkg::tmc_bus_req_s bus_req;
    int n_errors = 0;
    int compares = 0;
    int div[5] = '{1, 8, 64, 256, 1024};
    logic [1:0] code[3] = '{2'h3, 2'h2, 2'h1};
    logic exp_pin[3] = '{1'b1, 1'b0, 1'b1};

    tmc_timer8 u_dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(rdata),
        .global_irq_enable(gie), .overflow_ack(ovf_ack), .compare_ack(cmp_ack),
        .irq_overflow(irq_ovf), .irq_compare(irq_cmp), .irq(irq),
        .external_count_pin(ext_pin), .port_data_out(pdo), .port_dir_out(pdir),
        .waveform_output_pin(pin), .waveform_output_pin_oe(pin_oe));
    // ----------------------------------------
    // Bus, acknowledge and report tasks
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, e, d)
    endtask : rd_chk
    task automatic run(input logic [7:0] ctl, input logic [7:0] cnt, input int n);
        wr(CNT, cnt);
        wr(CTL, ctl);
        repeat (n) @(posedge clk);
        wr(CTL, ctl & 8'hF8);
    endtask : run
    task automatic pulse(input bit ovf);
        if (ovf) ovf_ack <= 1'b1; else cmp_ack <= 1'b1;
        @(posedge clk);
        ovf_ack <= 1'b0;
        cmp_ack <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    endtask : pulse
    task automatic final_report;
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial
    begin
        reset_n = 1'b0; bus_req = '0; gie = 1'b0; ovf_ack = 1'b0; cmp_ack = 1'b0;
        ext_pin = 1'b0; pdo = 1'b0; pdir = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00, "reset");
        wr(CTL, 8'hF8);
        rd_chk(CTL, 8'h78, "control");
        wr(MSK, 8'hFF);
        rd_chk(MSK, 8'h03, "mask");
        wr(CNT, 8'hA5);
        rd_chk(CNT, 8'hA5, "count");
        wr(3'h5, 8'hFF);
        rd_chk(3'h5, 8'h00, "unmapped");
        wr(CTL, 8'h00);
        wr(MSK, 8'h00);
        wr(CMP, 8'h03);
        pdir <= 1'b1;
        pdo <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("pin_port", 1'b1, pin)
        for (int i = 0; i < 3; i++)
        begin
            run({2'h0, code[i], 4'h1}, 8'h00, 8);
            `CHK("pin_code", exp_pin[i], pin)
        end
        pdo <= 1'b0;
        wr(CTL, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("pin_off", 1'b0, pin)
        pdir <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("pin_oe", 1'b0, pin_oe)
        wr(FLG, 8'h03);
        wr(CMP, 8'h20);
        run(8'h01, 8'h20, 5);
        rd_chk(FLG, 8'h00, "blocked");
        rd_chk(CNT, 8'h27, "ticks");
        wr(MSK, 8'h03);
        gie <= 1'b1;
        run(8'h01, 8'h1E, 5);
        rd_chk(FLG, 8'h01, "cmp_flag");
        `CHK("irq_cmp", 1'b1, irq_cmp)
        gie <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("irq_off", 1'b0, irq)
        gie <= 1'b1;
        wr(FLG, 8'h00);
        rd_chk(FLG, 8'h01, "w0");
        pulse(1'b0);
        `CHK("cmp_ack", 1'b0, irq_cmp)
        rd_chk(FLG, 8'h00, "cmp_clr");
        run(8'h01, 8'hFD, 4);
        `CHK("irq_ovf", 1'b1, irq_ovf)
        rd_chk(FLG, 8'h02, "ovf_flag");
        pulse(1'b1);
        rd_chk(FLG, 8'h00, "ovf_clr");
        wr(MSK, 8'h00);
        run(8'h41, 8'hF0, 290);
        rd_chk(FLG, 8'h03, "phase_ovf");
        wr(FLG, 8'h03);
        rd_chk(FLG, 8'h00, "w1c");
        wr(CMP, 8'h80);
        pdir <= 1'b1;
        run(8'h69, 8'h7C, 6);
        `CHK("fast_clr", 1'b0, pin)
        run(8'h69, 8'hFC, 6);
        `CHK("fast_top", 1'b1, pin)
        run(8'h79, 8'hFC, 6);
        `CHK("fast_inv", 1'b0, pin)
        run(8'h79, 8'h7C, 6);
        `CHK("fast_set", 1'b1, pin)
        run(8'h61, 8'h7C, 6);
        `CHK("phase_up", 1'b0, pin)
        run(8'h61, 8'h84, 250);
        `CHK("phase_dn", 1'b1, pin)
        wr(CMP, 8'hFF);
        run(8'h79, 8'hFC, 6);
        `CHK("pwm_top", 1'b0, pin)
        wr(CMP, 8'h05);
        run(8'h09, 8'h00, 40);
        rd(CNT, c);
        `CHK("ctc_top", 8'h00, c)
        for (int i = 0; i < 5; i++)
        begin
            run(8'(i + 1), 8'h00, 4 * div[i] - 2);
            rd(CNT, c);
            `CHK("prescale", 8'h04, c)
        end
        for (int e = 6; e < 8; e++)
        begin
            wr(CNT, 8'h00);
            wr(CTL, 8'(e));
            repeat (3)
            begin
                ext_pin <= 1'b1;
                repeat (3) @(posedge clk);
                ext_pin <= 1'b0;
                repeat (3) @(posedge clk);
            end
            repeat (5) @(posedge clk);
            wr(CTL, 8'h00);
            rd_chk(CNT, 8'h03, "external");
        end
        final_report();
    end
endmodule : test_tmc_timer8
`default_nettype wire

/* File: verification/tmc_timer8_checker.sv */
// Checker: port-level assertions for the 8-bit compare timer
`timescale 1ns/10ps
`default_nettype none
module tmc_timer8_checker
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset_n,
    // Register port
    input wire tmc_pkg::tmc_bus_req_s  bus_req,
    input wire logic [7:0]             bus_rdata,
    // Interrupt side
    input wire logic                   global_irq_enable,
    input wire logic                   overflow_ack,
    input wire logic                   compare_ack,
    input wire logic                   irq_overflow,
    input wire logic                   irq_compare,
    input wire logic                   irq,
    // Port pins
    input wire logic                   external_count_pin,
    input wire logic                   port_data_out,
    input wire logic                   port_dir_out,
    input wire logic                   waveform_output_pin,
    input wire logic                   waveform_output_pin_oe
);
    // ----------------------------------------
    // Shadow of control and mask
    // ----------------------------------------
    logic [7:0] ctl_reg;
    logic [1:0] msk_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_reg <= 8'h00;
            msk_reg <= 2'h0;
        end
        else if (bus_req.wr && bus_req.addr == tmc_pkg::TMC_OFF_CONTROL)
            ctl_reg <= bus_req.wdata & 8'h7F;
        else if (bus_req.wr && bus_req.addr == tmc_pkg::TMC_OFF_MASK)
            msk_reg <= bus_req.wdata[1:0];
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_count_wr;
        bus_req.wr && bus_req.addr == tmc_pkg::TMC_OFF_COUNT && ctl_reg[2:0] == 3'h0;
    endsequence
    sequence s_count_rd;
        bus_req.rd && bus_req.addr == tmc_pkg::TMC_OFF_COUNT && ctl_reg[2:0] == 3'h0;
    endsequence
    a_count_readback: assert property (s_count_wr ##2 s_count_rd |=>
        bus_rdata == $past(bus_req.wdata, 3)) else $error("count readback differs");
    a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > 3'h4 |=>
        bus_rdata == 8'h00) else $error("unmapped read not zero");
    a_port_passthru: assert property (ctl_reg[5:4] == 2'h0
        && !(bus_req.wr && bus_req.addr == tmc_pkg::TMC_OFF_CONTROL)
        |=> waveform_output_pin == $past(port_data_out)) else $error("pin not port value");
    a_oe_follows: assert property (1'b1 |=>
        waveform_output_pin_oe == $past(port_dir_out)) else $error("output enable not direction");
    a_ovf_enable: assert property (irq_overflow |-> msk_reg[1]
        && $past(global_irq_enable)) else $error("overflow request unmasked");
    a_cmp_enable: assert property (irq_compare |-> msk_reg[0]
        && $past(global_irq_enable)) else $error("compare request unmasked");
    a_irq_sum: assert property (irq == (irq_overflow || irq_compare))
        else $error("combined request wrong");
    a_ack_clears: assert property (compare_ack && ctl_reg[2:0] == 3'h0 |=>
        !irq_compare) else $error("acknowledge did not clear");
    a_w1c_clears: assert property (bus_req.wr
        && bus_req.addr == tmc_pkg::TMC_OFF_FLAGS && bus_req.wdata[1]
        && ctl_reg[2:0] == 3'h0 |=> !irq_overflow) else $error("write one did not clear");
endmodule : tmc_timer8_checker

bind tmc_timer8 tmc_timer8_checker u_chk (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .global_irq_enable(global_irq_enable),
    .overflow_ack(overflow_ack), .compare_ack(compare_ack), .irq_overflow(irq_overflow),
    .irq_compare(irq_compare), .irq(irq), .external_count_pin(external_count_pin),
    .port_data_out(port_data_out), .port_dir_out(port_dir_out),
    .waveform_output_pin(waveform_output_pin),
    .waveform_output_pin_oe(waveform_output_pin_oe));
`default_nettype wire
